// [hdl/sar_ctl_pkg.sv]
// Constants and types shared by the converter control logic
package sar_ctl_pkg;
  localparam int unsigned RESULT_W = 8;
  localparam int unsigned CHAN_W = 2;
  localparam int unsigned PRESC_W = 3;
  localparam int unsigned TRIG_W = 3;
  localparam int unsigned CYC_W = 5;
  // Converter clock cycles per conversion
  localparam logic [CYC_W-1:0] CONV_NORMAL_CYC = 5'h0d;
  localparam logic [CYC_W-1:0] CONV_FIRST_CYC = 5'h19;
  // Sample point, converter clocks after start
  localparam logic [CYC_W-1:0] SAMPLE_NORMAL_CYC = 5'h03;
  localparam logic [CYC_W-1:0] SAMPLE_FIRST_CYC = 5'h10;
  localparam logic [CYC_W-1:0] SAMPLE_AUTO_CYC = 5'h02;
  // System clocks added for trigger synchronisation
  localparam logic [1:0] TRIG_SYNC_CYC = 2'h3;
  localparam logic [RESULT_W-1:0] RESULT_RST = 8'h00;
  localparam logic [RESULT_W-1:0] RESULT_FULL = 8'hff;
  localparam logic [CHAN_W-1:0] CHAN_RST = 2'h0;
  localparam logic [6:0] DIV_RST = 7'h00;
  // Trigger source code that selects the own completion flag
  localparam logic [TRIG_W-1:0] TRIG_FREE_RUN = 3'h0;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_CONV = 2'b10
  } conv_state_e;
endpackage

// [hdl/sar_adc_conversion_control.sv]
// Conversion control for an 8-bit successive-approximation converter
// What this block does and what it relies on
// RQ1: Converter runs only while the power gate bit is clear.
// RQ2: Enable activates converter; channel applies only once enabled.
// RQ3: Each conversion yields an 8-bit unsigned result into result register.
// RQ4: Channel select routes one of four inputs to sample-and-hold.
// RQ5: Start bit begins a conversion, reads one throughout, self clears.
// RQ6: Channel change during conversion applies after it completes.
// RQ7: Auto-trigger rising edge resets prescaler and starts conversion.
// RQ8: Trigger edges during conversion ignored; held level starts nothing.
// RQ9: Trigger flags set regardless of masking; software clears them.
// RQ10: Completion flag as source gives back-to-back conversions.
// RQ11: Start bit works under auto-trigger and reads one when busy.
// RQ12: Prescaler divides per select field, held reset while disabled.
// RQ13: Software keeps converter clock between 50 and 200 kHz.
// RQ14: Start-bit conversion begins at next converter clock edge.
// RQ15: Normal conversion 13 converter clocks, first after enable 25.
// RQ16: Sample at 3 clocks normally, 16 on first conversion.
// RQ17: Completion writes result, sets done flag, clears start bit.
// RQ18: Auto-triggered sample two converter clocks after edge plus sync.
// RQ19: Free running restarts immediately while start bit stays set.
// RQ20: Channel copied continuously, frozen once a conversion starts.
// RQ21: Copying resumes in the last converter clock before done.
// RQ22: Software waits one converter clock after start before reselecting.
// RQ23: Under auto-trigger software changes channel only in safe windows.
// RQ24: Channel codes zero to three pick inputs zero to three.
// RQ25: Inputs above reference saturate the result at all ones.
// RQ26: In noise-reduction sleep, idle enabled converter starts on halt while auto-trigger is off.
// RQ27: Done flag clears on vector taken or writing one.
// RQ28: Done flag with interrupt enable raises an interrupt request.
`timescale 1ns/1ns
module sar_adc_conversion_control
  import sar_ctl_pkg::*;
#(
  parameter int unsigned NUM_TRIG = 8
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic converter_power_gate,
  input wire logic converter_enable,
  input wire logic auto_trigger_enable,
  input wire logic [TRIG_W-1:0] trigger_source_select,
  input wire logic [PRESC_W-1:0] clock_divider_select,
  input wire logic [CHAN_W-1:0] channel_select,
  input wire logic start_write,
  input wire logic done_irq_enable,
  input wire logic done_clear_write,
  input wire logic done_vector_taken,
  input wire logic sleep_noise_reduce,
  input wire logic cpu_halted,
  input wire logic [NUM_TRIG-1:0] trigger_flags,
  input wire logic [CHAN_W+RESULT_W-1:0] analog_level [4],
  output logic start_conversion_bit,
  output logic conversion_done_flag,
  output logic [RESULT_W-1:0] conversion_result_register,
  output logic [CHAN_W-1:0] active_channel,
  output logic sample_hold,
  output logic analog_powered,
  output logic irq_request
);

  ////////////////////////////////////////////////////////////////////////
  // Power, trigger edge, prescaler
  conv_state_e state_q, state_d;
  logic run;
  logic trig_sel, trig_prev_q, trig_edge;
  logic [1:0] trig_sync_q;
  logic trig_pend_q;
  logic [6:0] div_q;
  logic adc_tick;
  logic [6:0] div_mask;
  logic first_q;
  logic auto_q;
  logic [CYC_W-1:0] cyc_q;
  logic [CYC_W-1:0] conv_len, sample_at;
  logic last_cyc, done_evt, busy;
  logic sleep_start, sleep_prev_q;
  logic [CHAN_W-1:0] chan_tmp_q;
  logic [CHAN_W+RESULT_W-1:0] level_sel;
  logic [RESULT_W-1:0] held_q;
  logic free_src, start_req_q, launch;

  assign run = converter_enable & ~converter_power_gate; // [RQ1] [RQ2]
  assign analog_powered = run;
  // Own completion flag as source; otherwise a trigger flag by index
  assign free_src = (trigger_source_select == TRIG_FREE_RUN);
  assign trig_sel = trigger_flags[trigger_source_select];
  // Flags are sampled from other logic on this clock; edge is on flag level
  assign trig_edge = run & auto_trigger_enable & ~free_src & trig_sel &
                     ~trig_prev_q; // [RQ7] [RQ9]

  // Divide by 2**(select), select 0 behaves as 1 -> divide by 2
  assign div_mask = (clock_divider_select == 3'h0) ? 7'h01 :
                    7'((8'h01 << clock_divider_select) - 8'h01);
  assign adc_tick = run & ((div_q & div_mask) == div_mask); // [RQ12]

  ////////////////////////////////////////////////////////////////////////
  // Conversion sequencing
  assign conv_len = first_q ? CONV_FIRST_CYC : CONV_NORMAL_CYC; // [RQ15]
  assign sample_at = auto_q ? SAMPLE_AUTO_CYC :
                     (first_q ? SAMPLE_FIRST_CYC :
                      SAMPLE_NORMAL_CYC); // [RQ16] [RQ18]
  assign last_cyc = (state_q == ST_CONV) &&
                    (cyc_q == conv_len - 5'h01);
  assign done_evt = last_cyc & adc_tick;
  assign busy = (state_q != ST_IDLE);
  assign sleep_start = run & sleep_noise_reduce & cpu_halted &
                       ~sleep_prev_q & ~busy & ~auto_trigger_enable; // [RQ26]
  // Start request from software, sleep, or a synchronised trigger; free running restarts in the state machine
  assign launch = start_req_q | trig_pend_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE: if (launch && run) state_d = ST_WAIT;
      ST_WAIT: if (adc_tick) state_d = ST_CONV; // [RQ14]
      ST_CONV: if (done_evt) begin
        // Back to back only for own-flag source with start still set
        if (auto_trigger_enable && free_src) state_d = ST_CONV; // [RQ10] [RQ19]
        else state_d = ST_IDLE;
      end
      default: state_d = ST_IDLE;
    endcase
    if (!run) state_d = ST_IDLE;
  end

  // Channel path: 4-way select; codes map in order
  assign level_sel = analog_level[active_channel]; // [RQ4] [RQ24]

  ////////////////////////////////////////////////////////////////////////
  // Registers
  logic trig_take, idle_launch, chan_open, sample_now;
  // A trigger counts only while idle; edges during a conversion drop
  assign trig_take = trig_edge & ~busy; // [RQ8]
  assign idle_launch = (state_q == ST_IDLE) & launch;
  assign chan_open = run & ((state_q != ST_CONV) | last_cyc);
  assign sample_now = (state_q == ST_CONV) & adc_tick & (cyc_q == sample_at);

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div_q <= DIV_RST;
    end else if (!run || trig_take) begin
      div_q <= DIV_RST; // [RQ7] [RQ12]
    end else begin
      div_q <= div_q + 7'h01;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Previous flag level; a held level never looks like a new edge
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      trig_prev_q <= 1'b0;
    end else begin
      trig_prev_q <= trig_sel; // [RQ8]
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sleep_prev_q <= 1'b0;
    end else begin
      sleep_prev_q <= sleep_noise_reduce & cpu_halted;
    end
  end

  // Synchronisation delay before the trigger reaches the sequencer
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      trig_sync_q <= 2'h0;
    end else if (trig_take) begin
      trig_sync_q <= TRIG_SYNC_CYC; // [RQ18]
    end else if (trig_sync_q != 2'h0) begin
      trig_sync_q <= trig_sync_q - 2'h1;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      trig_pend_q <= 1'b0;
    end else begin
      trig_pend_q <= (trig_sync_q == 2'h1) & run; // [RQ18]
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      start_req_q <= 1'b0;
    end else if (!run || idle_launch) begin
      start_req_q <= 1'b0;
    end else if (start_write || sleep_start) begin
      start_req_q <= 1'b1; // [RQ11]
    end
  end

  // First conversion after enable runs long for analog settling
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      first_q <= 1'b1;
    end else if (!run) begin
      first_q <= 1'b1; // [RQ15]
    end else if (done_evt) begin
      first_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      auto_q <= 1'b0;
    end else if (idle_launch) begin
      auto_q <= trig_pend_q & ~start_req_q; // [RQ18]
    end else if (done_evt) begin
      auto_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cyc_q <= 5'h00;
    end else if (state_q != ST_CONV || done_evt) begin
      cyc_q <= 5'h00;
    end else if (adc_tick) begin
      cyc_q <= cyc_q + 5'h01;
    end
  end

  // Start bit: set by request, held while busy, cleared at a completion that returns to idle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      start_conversion_bit <= 1'b0;
    end else if (!run) begin
      start_conversion_bit <= 1'b0;
    end else if (start_write || sleep_start || launch) begin
      start_conversion_bit <= 1'b1; // [RQ5] [RQ11]
    end else if (done_evt && state_d == ST_IDLE) begin
      start_conversion_bit <= 1'b0; // [RQ17]
    end
  end

  // Done flag: hardware set wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      conversion_done_flag <= 1'b0;
    end else if (done_evt) begin
      conversion_done_flag <= 1'b1; // [RQ17]
    end else if (done_clear_write || done_vector_taken) begin
      conversion_done_flag <= 1'b0; // [RQ27]
    end
  end

  assign irq_request = conversion_done_flag & done_irq_enable; // [RQ28]

  // Channel copy runs every cycle; active channel loads while running, outside ST_CONV and in its last cycle, frozen otherwise
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      chan_tmp_q <= CHAN_RST;
    end else begin
      chan_tmp_q <= channel_select; // [RQ20]
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      active_channel <= CHAN_RST;
    end else if (chan_open) begin
      active_channel <= chan_tmp_q; // [RQ2] [RQ6] [RQ20] [RQ21]
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sample_hold <= 1'b0;
    end else begin
      sample_hold <= sample_now; // [RQ16]
    end
  end

  // Sample, then saturate above-reference levels to full code
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      held_q <= RESULT_RST;
    end else if (sample_hold) begin
      held_q <= (level_sel[CHAN_W+RESULT_W-1:RESULT_W] != 2'h0) ?
                RESULT_FULL : level_sel[RESULT_W-1:0]; // [RQ25]
    end
  end

  // Result only moves at completion, so software never sees a half value
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      conversion_result_register <= RESULT_RST;
    end else if (done_evt) begin
      conversion_result_register <= held_q; // [RQ3] [RQ17]
    end
  end

endmodule

// [testbench/sar_ctl_properties.sv]
// Port-level assertions for the converter control block
`timescale 1ns/1ns
module sar_ctl_properties
  import sar_ctl_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic converter_power_gate,
  input wire logic converter_enable,
  input wire logic auto_trigger_enable,
  input wire logic [PRESC_W-1:0] clock_divider_select,
  input wire logic start_write,
  input wire logic done_irq_enable,
  input wire logic done_clear_write,
  input wire logic done_vector_taken,
  input wire logic start_conversion_bit,
  input wire logic conversion_done_flag,
  input wire logic [RESULT_W-1:0] conversion_result_register,
  input wire logic [CHAN_W-1:0] active_channel,
  input wire logic sample_hold,
  input wire logic analog_powered,
  input wire logic irq_request
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////
  AST_GATE_OFF: assert property (converter_power_gate |-> !analog_powered && !sample_hold) else $error("gated converter active");
  AST_POWER: assert property (analog_powered == (converter_enable && !converter_power_gate)) else $error("power state wrong");
  AST_CHAN_EN: assert property ($changed(active_channel) |-> $past(analog_powered)) else $error("channel moved while off");
  AST_IRQ: assert property (irq_request == (conversion_done_flag && done_irq_enable)) else $error("irq mismatch");
  AST_START: assert property (start_write && analog_powered |=> start_conversion_bit) else $error("start not taken");
  AST_CLEAR: assert property ($fell(conversion_done_flag) |-> $past(done_clear_write || done_vector_taken)) else $error("done lost");
  AST_RESULT: assert property ($changed(conversion_result_register) |-> conversion_done_flag) else $error("result without done");
  AST_DROP: assert property ($fell(start_conversion_bit) && analog_powered |-> conversion_done_flag) else $error("start fell early");
  AST_SAMPLE: assert property (sample_hold |-> start_conversion_bit) else $error("sample while idle");
  // Select 0 only (divide by 2); select 1 also divides by 2, settings 2 and up exceed a sane delay window
  AST_LEN: assert property (start_write && analog_powered && !start_conversion_bit && !auto_trigger_enable && clock_divider_select == 3'h0 |-> ##[26:60] $fell(start_conversion_bit)) else $error("length off");
  COV_SAMPLE: cover property (sample_hold);
  COV_AUTO: cover property ($rose(conversion_done_flag) && auto_trigger_enable);
  COV_DROP: cover property ($fell(start_conversion_bit));
endmodule
bind sar_adc_conversion_control sar_ctl_properties sar_ctl_properties_inst (
  .clk_sys, .reset_n, .converter_power_gate, .converter_enable,
  .auto_trigger_enable, .clock_divider_select, .start_write,
  .done_irq_enable, .done_clear_write, .done_vector_taken,
  .start_conversion_bit, .conversion_done_flag, .conversion_result_register,
  .active_channel, .sample_hold, .analog_powered, .irq_request);

// [testbench/analog_front_model.sv]
// Four analog inputs whose levels the bench sets
`timescale 1ns/1ns
module analog_front_model
  import sar_ctl_pkg::*;
(
  output logic [CHAN_W+RESULT_W-1:0] analog_level [4]
);
  // Nonzero upper bits stand for a level above the reference
  task automatic set_level(input int ch, input logic [9:0] v);
    analog_level[ch] = v;
  endtask
endmodule

// [testbench/tb_sar_adc_conversion_control.sv]
// Self-checking bench for the converter control block
`timescale 1ns/1ns
module tb_sar_adc_conversion_control
  import sar_ctl_pkg::*;
;
  logic clk_sys, reset_n, gate, en, ate, start_wr, irq_en, clr_wr;
  logic [2:0] tsel, dsel;
  logic [1:0] chan;
  logic [7:0] tflags;
  wire start_bit, done, irq, powered, sh;
  wire [7:0] result;
  wire [1:0] act_ch;
  wire [9:0] lvl [4];
  int errors, checked, n, shots;
  logic [7:0] exp_res [4] = '{8'h11, 8'ha5, 8'h5a, 8'hff};
  analog_front_model analog_front_model_inst (.analog_level(lvl));
  sar_adc_conversion_control #(.NUM_TRIG(8)) sar_adc_conversion_control_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .converter_power_gate(gate),
    .converter_enable(en), .auto_trigger_enable(ate),
    .trigger_source_select(tsel), .clock_divider_select(dsel),
    .channel_select(chan), .start_write(start_wr), .done_irq_enable(irq_en),
    .done_clear_write(clr_wr), .done_vector_taken(1'b0),
    .sleep_noise_reduce(1'b0), .cpu_halted(1'b0), .trigger_flags(tflags),
    .analog_level(lvl), .start_conversion_bit(start_bit),
    .conversion_done_flag(done), .conversion_result_register(result),
    .active_channel(act_ch), .sample_hold(sh), .analog_powered(powered),
    .irq_request(irq));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk_sys);
    #1;
  endtask
  task automatic pulse_clear();
    clr_wr = 1'b1;
    step(1);
    clr_wr = 1'b0;
  endtask
  // Moves the channel ten cycles in, well after the start was taken
  task automatic wait_done(input logic [1:0] later, output int c);
    c = 1;
    while (done !== 1'b1 && c < 200) begin
      if (c == 10) chan = later;
      if (sh === 1'b1) shots++;
      step(1);
      c++;
    end
    if (c >= 200) begin
      errors++;
      close_out();
    end
  endtask
  task automatic run(input logic [1:0] later, output int c);
    pulse_clear();
    shots = 0;
    start_wr = 1'b1;
    step(1);
    start_wr = 1'b0;
    wait_done(later, c);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_n, gate, ate, start_wr, clr_wr} = '0;
    {en, irq_en, tsel, dsel, chan, tflags} = {2'b11, 3'h1, 3'h0, 2'h2, 8'h00};
    {errors, checked} = '0;
    for (int i = 0; i < 3; i++)
      analog_front_model_inst.set_level(i, {2'b00, exp_res[i]});
    analog_front_model_inst.set_level(3, 10'h123);
    step(6);
    reset_n = 1'b1;
    gate = 1'b1;
    start_wr = 1'b1;
    step(1);
    start_wr = 1'b0;
    step(2);
    check("gated start", {7'h00, start_bit}, 8'h00);
    check("gated power", {7'h00, powered}, 8'h00);
    {gate, en} = 2'b00;
    step(1);
    en = 1'b1;
    run(chan, n);
    check("first length", 8'(n >= 50 && n <= 56), 8'h01);
    check("first result", result, 8'h5a);
    check("start bit", {7'h00, start_bit}, 8'h00);
    check("irq", {7'h00, irq}, 8'h01);
    for (int i = 0; i < 4; i++) begin
      chan = 2'(i);
      run(chan, n);
      check("normal length", 8'(n >= 26 && n <= 32), 8'h01);
      check("channel result", result, exp_res[i]);
      check("active channel", {6'h00, act_ch}, 8'(i));
      check("sample pulses", 8'(shots), 8'h01);
    end
    chan = 2'h0;
    run(2'h1, n);
    check("old channel kept", result, 8'h11);
    dsel = 3'h2;
    run(chan, n);
    check("new channel", result, 8'ha5);
    check("divide by 4", 8'(n >= 52 && n <= 62), 8'h01);
    irq_en = 1'b0;
    step(1);
    check("irq masked", {7'h00, irq}, 8'h00);
    {dsel, ate} = {3'h0, 1'b1};
    pulse_clear();
    tflags = 8'h02;
    wait_done(chan, n);
    check("auto result", result, 8'ha5);
    check("auto length", 8'(n <= 40), 8'h01);
    step(40);
    check("held trigger", {7'h00, start_bit}, 8'h00);
    {tflags, tsel} = {8'h00, 3'h0};
    run(chan, n);
    step(1);
    check("free run busy", {7'h00, start_bit}, 8'h01);
    pulse_clear();
    wait_done(chan, n);
    check("free run next", 8'(n <= 32), 8'h01);
    en = 1'b0;
    step(2);
    close_out();
  end
endmodule
